// ==== hdl/sis_pkg.sv ====
// Package: register map, field positions and reset values of the SCSI interrupt status block
package sis_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_SUMMARY = 8'h14;
  localparam logic [7:0] IDX_EN0 = 8'h40;
  localparam logic [7:0] IDX_EN1 = 8'h41;
  localparam logic [7:0] IDX_ST0 = 8'h42;
  localparam logic [7:0] IDX_ST1 = 8'h43;
  localparam logic [7:0] IDX_IDCFG = 8'h50;
  localparam int AW = 12;
  localparam logic [AW-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [AW-1:0] ADDR_SUMMARY = {2'h0, IDX_SUMMARY, 2'h0};
  localparam logic [AW-1:0] ADDR_EN0 = {2'h0, IDX_EN0, 2'h0};
  localparam logic [AW-1:0] ADDR_EN1 = {2'h0, IDX_EN1, 2'h0};
  localparam logic [AW-1:0] ADDR_ST0 = {2'h0, IDX_ST0, 2'h0};
  localparam logic [AW-1:0] ADDR_ST1 = {2'h0, IDX_ST1, 2'h0};
  localparam logic [AW-1:0] ADDR_IDCFG = {2'h0, IDX_IDCFG, 2'h0};
  // First status register fields
  localparam int B_PM = 7;
  localparam int B_CMP = 6;
  localparam int B_SEL = 5;
  localparam int B_RSL = 4;
  localparam int B_SGE = 3;
  localparam int B_UDC = 2;
  localparam int B_RST = 1;
  localparam int B_PAR = 0;
  // Second status register fields; bits 7..3 reserved
  localparam int B_STO = 2;
  localparam int B_GEN = 1;
  localparam int B_HTH = 0;
  localparam int ST1_W = 3;
  // Control and id-config fields
  localparam int B_PAR_EN = 3;
  localparam int B_HOST_PAR_OFF = 2;
  localparam int B_RESP_SEL = 1;
  localparam int B_RESP_RESEL = 0;
  // Summary register fields
  localparam int B_SIP = 1;
  localparam int B_DIP = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [ST1_W-1:0] RST_ST1 = 3'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/sis_scsi_int_status.sv ====
// SCSI interrupt status registers with stacking, summary flag and latched request
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
// Status byte with stacking behind it
module sis_stack #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] evt,
  input wire logic rd_clr,
  input wire logic stack_en,
  output logic [W-1:0] cur
);
  logic [W-1:0] stk;
  logic [W-1:0] next_cur;
  logic [W-1:0] next_stk;

  // Read drops visible bits; stacked and same-cycle events fall through
  assign next_cur = rd_clr ? (stk | evt) : (stack_en ? cur : (cur | evt));
  assign next_stk = rd_clr ? '0 : (stack_en ? (stk | evt) : stk);

  // Both held bytes clear at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      stk <= '0;
    end else begin
      cur <= next_cur;
      stk <= next_stk;
    end
  end
endmodule // sis_stack

////////////////////////////////////////////////////////////////////////
// Top: AXI4-Lite slave around the two status registers
module sis_scsi_int_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic initiator_mode,
  input wire logic target_mode,
  input wire logic low_level_mode,
  input wire logic req_phase_evt,
  input wire logic [2:0] bus_phase,
  input wire logic [2:0] expected_phase,
  input wire logic atn_evt,
  input wire logic phase_change_evt,
  input wire logic arb_sel_done_evt,
  input wire logic selected_evt,
  input wire logic reselected_evt,
  input wire logic fifo_underflow_evt,
  input wire logic fifo_overflow_evt,
  input wire logic ack_evt,
  input wire logic offset_zero,
  input wire logic offset_over_evt,
  input wire logic residual_start_evt,
  input wire logic offset_outstanding,
  input wire logic disconnect_evt,
  input wire logic expected_disc,
  input wire logic scsi_rst_n,
  input wire logic scsi_par_err_evt,
  input wire logic host_par_err_evt,
  input wire logic sel_timeout_evt,
  input wire logic gen_timer_evt,
  input wire logic hs_timer_evt,
  input wire logic dma_int_pending_flag,
  output logic scsi_int_pending_flag,
  output logic scsi_irq
);
  logic [7:0] first_control_register;
  logic [7:0] chip_id_config_register;
  logic [7:0] scsi_int_enable_first;
  logic [sis_pkg::ST1_W-1:0] scsi_int_enable_second;
  logic [7:0] scsi_int_status_first;
  logic [sis_pkg::ST1_W-1:0] scsi_int_status_second;
  logic [11:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic rst_s1;
  logic rst_s2;
  logic rst_prev;
  logic rd0_seen;
  logic rd1_seen;

  ////////////////////////////////////////////////////////////////////
  // Bus reset pin: two-flop synchroniser, then falling-edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
      rst_prev <= 1'b1;
    end else begin
      rst_s1 <= scsi_rst_n;
      rst_s2 <= rst_s1;
      rst_prev <= rst_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Condition sources for the first status byte
  logic pm_evt;
  logic sge_evt;
  logic udc_evt;
  logic rst_evt;
  logic par_evt;
  logic par_en;
  logic [7:0] evt0;
  logic [sis_pkg::ST1_W-1:0] evt1;

  assign par_en = first_control_register[sis_pkg::B_PAR_EN];
  assign pm_evt = (initiator_mode & req_phase_evt & (bus_phase != expected_phase))
    | (target_mode & atn_evt)
    | (low_level_mode & phase_change_evt);
  assign sge_evt = fifo_underflow_evt | fifo_overflow_evt
    | (target_mode & ack_evt & offset_zero) | offset_over_evt
    | residual_start_evt
    | (initiator_mode & phase_change_evt & offset_outstanding);
  // Time-out counts as unexpected even outside initiator mode
  assign udc_evt = (initiator_mode & disconnect_evt & ~expected_disc)
    | (low_level_mode & disconnect_evt)
    | sel_timeout_evt;
  // Only the edge counts, so a long reset pulse raises one condition
  assign rst_evt = rst_prev & ~rst_s2;
  assign par_evt = par_en & (scsi_par_err_evt
    | (host_par_err_evt & ~first_control_register[sis_pkg::B_HOST_PAR_OFF]));

  // Bit packing of the event vectors
  always_comb begin
    evt0 = '0;
    evt0[sis_pkg::B_PM] = pm_evt;
    evt0[sis_pkg::B_CMP] = arb_sel_done_evt;
    evt0[sis_pkg::B_SEL] = selected_evt & chip_id_config_register[sis_pkg::B_RESP_SEL];
    evt0[sis_pkg::B_RSL] = reselected_evt
      & chip_id_config_register[sis_pkg::B_RESP_RESEL];
    evt0[sis_pkg::B_SGE] = sge_evt;
    evt0[sis_pkg::B_UDC] = udc_evt;
    evt0[sis_pkg::B_RST] = rst_evt;
    evt0[sis_pkg::B_PAR] = par_evt;
    evt1 = '0;
    evt1[sis_pkg::B_STO] = sel_timeout_evt;
    evt1[sis_pkg::B_GEN] = gen_timer_evt;
    evt1[sis_pkg::B_HTH] = hs_timer_evt;
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes and decode
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic wr_mapped;
  logic rd0;
  logic rd1;
  logic rd_any;
  logic rd_mapped;
  logic [7:0] rd_byte;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  // Both halves held and no answer outstanding
  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_mapped = (aw_addr == sis_pkg::ADDR_CTRL) | (aw_addr == sis_pkg::ADDR_IDCFG)
    | (aw_addr == sis_pkg::ADDR_EN0) | (aw_addr == sis_pkg::ADDR_EN1)
    | (aw_addr == sis_pkg::ADDR_ST0) | (aw_addr == sis_pkg::ADDR_ST1)
    | (aw_addr == sis_pkg::ADDR_SUMMARY);
  assign rd0 = ar_hs & (s_axi_araddr == sis_pkg::ADDR_ST0);
  assign rd1 = ar_hs & (s_axi_araddr == sis_pkg::ADDR_ST1);
  assign rd_any = rd0 | rd1;

  // Read data select; status shows all bits regardless of enables
  always_comb begin
    rd_byte = sis_pkg::RST_BYTE;
    rd_mapped = 1'b1;
    if (s_axi_araddr == sis_pkg::ADDR_ST0) begin
      rd_byte = scsi_int_status_first;
    end else if (s_axi_araddr == sis_pkg::ADDR_ST1) begin
      rd_byte = {5'h00, scsi_int_status_second};
    end else if (s_axi_araddr == sis_pkg::ADDR_EN0) begin
      rd_byte = scsi_int_enable_first;
    end else if (s_axi_araddr == sis_pkg::ADDR_EN1) begin
      rd_byte = {5'h00, scsi_int_enable_second};
    end else if (s_axi_araddr == sis_pkg::ADDR_CTRL) begin
      rd_byte = first_control_register;
    end else if (s_axi_araddr == sis_pkg::ADDR_IDCFG) begin
      rd_byte = chip_id_config_register;
    end else if (s_axi_araddr == sis_pkg::ADDR_SUMMARY) begin
      rd_byte = {6'h00, scsi_int_pending_flag, dma_int_pending_flag};
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // Write channel: take address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sis_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_byte <= sis_pkg::RST_BYTE;
      w_lane0 <= 1'b0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? sis_pkg::RESP_OKAY : sis_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Software registers; status is read-only and ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_control_register <= sis_pkg::RST_BYTE;
      chip_id_config_register <= sis_pkg::RST_BYTE;
      scsi_int_enable_first <= sis_pkg::RST_BYTE;
      scsi_int_enable_second <= sis_pkg::RST_ST1;
    end else if (wr_fire & w_lane0) begin
      if (aw_addr == sis_pkg::ADDR_CTRL) begin
        first_control_register <= w_byte;
      end else if (aw_addr == sis_pkg::ADDR_IDCFG) begin
        chip_id_config_register <= w_byte;
      end else if (aw_addr == sis_pkg::ADDR_EN0) begin
        scsi_int_enable_first <= w_byte;
      end else if (aw_addr == sis_pkg::ADDR_EN1) begin
        scsi_int_enable_second <= w_byte[sis_pkg::ST1_W-1:0];
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sis_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_mapped ? sis_pkg::RESP_OKAY : sis_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status bytes; stacking starts once the summary flag is up
  sis_stack #(.W(8)) u_st0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(evt0),
    .rd_clr(rd0),
    .stack_en(scsi_int_pending_flag),
    .cur(scsi_int_status_first)
  );

  sis_stack #(.W(sis_pkg::ST1_W)) u_st1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(evt1),
    .rd_clr(rd1),
    .stack_en(scsi_int_pending_flag),
    .cur(scsi_int_status_second)
  );

  ////////////////////////////////////////////////////////////////////
  // Summary flag and latched request
  logic both_read;
  logic any_status;
  logic irq_set;
  logic next_sip;
  logic next_irq;

  assign both_read = (rd0_seen | rd0) & (rd1_seen | rd1);
  assign any_status = (|scsi_int_status_first) | (|scsi_int_status_second);
  assign irq_set = (|(scsi_int_status_first & scsi_int_enable_first))
    | (|(scsi_int_status_second & scsi_int_enable_second));
  // Summary drops only when both bytes have been read since it rose
  assign next_sip = scsi_int_pending_flag ? ~both_read : any_status;
  // Read drops the request; stacked enabled bits raise it a cycle later
  assign next_irq = rd_any ? 1'b0 : (scsi_irq | irq_set);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scsi_int_pending_flag <= 1'b0;
      scsi_irq <= 1'b0;
      rd0_seen <= 1'b0;
      rd1_seen <= 1'b0;
    end else begin
      scsi_int_pending_flag <= next_sip;
      scsi_irq <= next_irq;
      rd0_seen <= scsi_int_pending_flag & ~both_read & (rd0_seen | rd0);
      rd1_seen <= scsi_int_pending_flag & ~both_read & (rd1_seen | rd1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_STO_SET: assert property (sel_timeout_evt && !scsi_int_pending_flag
    |=> scsi_int_status_second[sis_pkg::B_STO] && scsi_int_status_first[sis_pkg::B_UDC])
    else $error("time-out not recorded");
  AST_GEN_SET: assert property (gen_timer_evt && !scsi_int_pending_flag |=>
    scsi_int_status_second[sis_pkg::B_GEN]) else $error("general timer not recorded");
  AST_HTH_SET: assert property (hs_timer_evt |=>
    scsi_int_status_second[sis_pkg::B_HTH] || $past(scsi_int_pending_flag))
    else $error("handshake timer not recorded");
  AST_READ_SHOWS: assert property (rd0 |=> s_axi_rvalid
    && s_axi_rdata[7:0] == $past(scsi_int_status_first)) else $error("status readback");
  AST_READ_CLEARS: assert property (rd1 && evt1 == '0 && u_st1.stk == '0
    |=> scsi_int_status_second == '0) else $error("read did not clear");
  AST_SIP_HOLD: assert property (scsi_int_pending_flag && !rd0 && !rd0_seen
    |=> scsi_int_pending_flag) else $error("summary cleared early");
  AST_PM_SET: assert property (initiator_mode && req_phase_evt
    && bus_phase != expected_phase && !scsi_int_pending_flag
    |=> scsi_int_status_first[sis_pkg::B_PM]) else $error("phase mismatch lost");
  AST_RST_EDGE: assert property ($fell(rst_s2) && !scsi_int_pending_flag
    |=> scsi_int_status_first[sis_pkg::B_RST]) else $error("bus reset lost");
  AST_IRQ_LATCH: assert property (scsi_irq && !rd_any |=> scsi_irq)
    else $error("request released without a read");

  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_STACK: cover property (rd0 && u_st0.stk != '0);
  COV_IRQ: cover property ($rose(scsi_irq));
  COV_SIP_CLR: cover property ($fell(scsi_int_pending_flag));
endmodule // sis_scsi_int_status

// ==== testbench/sis_host_model.sv ====
// Host model: AXI4-Lite master that reads and writes the status block
`timescale 1ns/100ps
module sis_host_model (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int unsigned cyc = 0;
  int unsigned last_st = 0;
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Free-running cycle count for read spacing
  always @(posedge aclk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // Read; status reads kept 12 clocks apart so clearing settles
  task automatic rd(input logic [11:0] a);
    if (a == sis_pkg::ADDR_ST0 || a == sis_pkg::ADDR_ST1) begin
      while (cyc - last_st < 12) @(posedge aclk);
    end
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    last_st = cyc;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule // sis_host_model

// ==== testbench/test_sis_scsi_int_status.sv ====
// Self-checking bench for the SCSI interrupt status block
`timescale 1ns/100ps
module test_sis_scsi_int_status;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic initiator_mode, target_mode, low_level_mode, req_phase_evt, atn_evt, phase_change_evt;
  logic arb_sel_done_evt, selected_evt, reselected_evt, fifo_underflow_evt, fifo_overflow_evt;
  logic ack_evt, offset_zero, offset_over_evt, residual_start_evt, offset_outstanding;
  logic disconnect_evt, expected_disc, scsi_par_err_evt, host_par_err_evt, sel_timeout_evt;
  logic gen_timer_evt, hs_timer_evt, scsi_int_pending_flag, scsi_irq;
  logic dma_int_pending_flag = 1'b0;
  logic scsi_rst_n = 1'b1;
  logic [2:0] bus_phase = 3'h0;
  logic [2:0] expected_phase = 3'h0;
  logic [15:0] e;
  logic [33:0] q[$];
  logic [1:0] bq[$];
  int failures = 0;
  int compares = 0;

  always #10 aclk = ~aclk;

  sis_scsi_int_status i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .initiator_mode, .target_mode, .low_level_mode, .req_phase_evt,
    .bus_phase, .expected_phase, .atn_evt, .phase_change_evt, .arb_sel_done_evt, .selected_evt,
    .reselected_evt, .fifo_underflow_evt, .fifo_overflow_evt, .ack_evt, .offset_zero,
    .offset_over_evt, .residual_start_evt, .offset_outstanding, .disconnect_evt, .expected_disc,
    .scsi_rst_n, .scsi_par_err_evt, .host_par_err_evt, .sel_timeout_evt, .gen_timer_evt,
    .hs_timer_evt, .dma_int_pending_flag, .scsi_int_pending_flag, .scsi_irq);

  sis_host_model i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

  ////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data and write responses checked against the oldest note as each answer is taken
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, q.pop_front());
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, bq.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////
  // Stimulus helpers
  task automatic clr;
    {initiator_mode, target_mode, low_level_mode, req_phase_evt, atn_evt} <= '0;
    {phase_change_evt, arb_sel_done_evt, selected_evt, reselected_evt} <= '0;
    {fifo_underflow_evt, fifo_overflow_evt, ack_evt, offset_zero, offset_over_evt} <= '0;
    {residual_start_evt, offset_outstanding, disconnect_evt, expected_disc} <= '0;
    {scsi_par_err_evt, host_par_err_evt, sel_timeout_evt, gen_timer_evt, hs_timer_evt} <= '0;
  endtask

  // One condition for one cycle; e gets the expected {first, second} status
  task automatic pulse(input int k, output logic [15:0] ex);
    logic [5:0] r;
    r = 6'($urandom);
    @(posedge aclk);
    bus_phase <= r[2:0];
    expected_phase <= r[2:0] ^ (r[5:3] | 3'h1);
    case (k)
      0: begin initiator_mode <= 1'b1; req_phase_evt <= 1'b1; ex = 16'h8000; end
      1: begin target_mode <= 1'b1; atn_evt <= 1'b1; ex = 16'h8000; end
      2: begin low_level_mode <= 1'b1; phase_change_evt <= 1'b1; ex = 16'h8000; end
      3: begin arb_sel_done_evt <= 1'b1; ex = 16'h4000; end
      4: begin selected_evt <= 1'b1; ex = 16'h2000; end
      5: begin reselected_evt <= 1'b1; ex = 16'h1000; end
      6: begin fifo_underflow_evt <= 1'b1; ex = 16'h0800; end
      7: begin fifo_overflow_evt <= 1'b1; ex = 16'h0800; end
      8: begin target_mode <= 1'b1; ack_evt <= 1'b1; offset_zero <= 1'b1; ex = 16'h0800; end
      9: begin offset_over_evt <= 1'b1; ex = 16'h0800; end
      10: begin residual_start_evt <= 1'b1; ex = 16'h0800; end
      11: begin initiator_mode <= 1'b1; offset_outstanding <= 1'b1; phase_change_evt <= 1'b1;
        ex = 16'h0800; end
      12: begin initiator_mode <= 1'b1; disconnect_evt <= 1'b1; ex = 16'h0400; end
      13: begin low_level_mode <= 1'b1; expected_disc <= 1'b1; disconnect_evt <= 1'b1;
        ex = 16'h0400; end
      14: begin scsi_par_err_evt <= 1'b1; ex = 16'h0100; end
      15: begin host_par_err_evt <= 1'b1; ex = 16'h0100; end
      16: begin sel_timeout_evt <= 1'b1; ex = 16'h0404; end
      17: begin gen_timer_evt <= 1'b1; ex = 16'h0002; end
      19: begin initiator_mode <= 1'b1; expected_disc <= 1'b1; disconnect_evt <= 1'b1;
        ex = 16'h0000; end
      default: begin hs_timer_evt <= 1'b1; ex = 16'h0001; end
    endcase
    @(posedge aclk);
    clr;
  endtask

  task automatic rd_exp(input logic [11:0] a, input logic [7:0] b,
                        input logic [1:0] rs = sis_pkg::RESP_OKAY);
    q.push_back({rs, 24'h0, b});
    i_host.rd(a);
  endtask

  // Write with its expected response noted first
  task automatic wr_exp(input logic [11:0] a, input logic [7:0] d,
                        input logic [1:0] rs = sis_pkg::RESP_OKAY);
    bq.push_back(rs);
    i_host.wr(a, d);
  endtask

  // Both status registers, first one first so nothing is missed
  task automatic read_both(input logic [15:0] ex);
    rd_exp(sis_pkg::ADDR_ST0, ex[15:8]);
    rd_exp(sis_pkg::ADDR_ST1, ex[7:0]);
  endtask

  // Watchdog, well beyond the expected run of roughly a thousand cycles
  initial begin
    repeat (30000) @(posedge aclk);
    failures++;
    end_of_test;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(51));
    clr;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, reserved bits, unmapped place
    wr_exp(sis_pkg::ADDR_ST1, 8'hFF);
    read_both(16'h0000);
    wr_exp(sis_pkg::ADDR_EN1, 8'hFF);
    rd_exp(sis_pkg::ADDR_EN1, 8'h07);
    wr_exp(sis_pkg::ADDR_EN1, 8'h00);
    // Lane 0 strobe low leaves the byte untouched
    s_axi_wstrb <= 4'hE;
    wr_exp(sis_pkg::ADDR_EN0, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rd_exp(sis_pkg::ADDR_EN0, 8'h00);
    wr_exp(12'hFFC, 8'h00, sis_pkg::RESP_SLVERR);
    rd_exp(12'hFFC, 8'h00, sis_pkg::RESP_SLVERR);
    dma_int_pending_flag <= 1'b1;
    rd_exp(sis_pkg::ADDR_SUMMARY, 8'h01);
    dma_int_pending_flag <= 1'b0;
    $display("done: reset values");
    // Every condition except bus reset, masked, one at a time
    wr_exp(sis_pkg::ADDR_IDCFG, 8'h03);
    wr_exp(sis_pkg::ADDR_CTRL, 8'h08);
    for (int k = 0; k < 19; k++) begin
      pulse(k, e);
      repeat (3) @(posedge aclk);
      check(scsi_int_pending_flag, 1'b1);
      check(scsi_irq, 1'b0);
      rd_exp(sis_pkg::ADDR_ST0, e[15:8]);
      check(scsi_int_pending_flag, 1'b1);
      rd_exp(sis_pkg::ADDR_ST1, e[7:0]);
      repeat (2) @(posedge aclk);
      check(scsi_int_pending_flag, 1'b0);
    end
    $display("done: condition table");
    // Stacking behind a pending condition
    pulse(3, e);
    repeat (2) @(posedge aclk);
    pulse(6, e);
    repeat (2) @(posedge aclk);
    rd_exp(sis_pkg::ADDR_SUMMARY, 8'h02);
    read_both(16'h4000);
    read_both(16'h0800);
    repeat (2) @(posedge aclk);
    check(scsi_int_pending_flag, 1'b0);
    $display("done: stacking");
    // Latched request survives masking
    wr_exp(sis_pkg::ADDR_EN0, 8'($urandom) | 8'h40);
    pulse(3, e);
    repeat (3) @(posedge aclk);
    check(scsi_irq, 1'b1);
    wr_exp(sis_pkg::ADDR_EN0, 8'h00);
    check(scsi_irq, 1'b1);
    read_both(16'h4000);
    repeat (2) @(posedge aclk);
    check(scsi_irq, 1'b0);
    $display("done: request latch");
    // Gated conditions leave no trace
    wr_exp(sis_pkg::ADDR_IDCFG, 8'h00);
    pulse(4, e);
    pulse(5, e);
    pulse(19, e);
    wr_exp(sis_pkg::ADDR_CTRL, 8'h0C);
    pulse(15, e);
    wr_exp(sis_pkg::ADDR_CTRL, 8'h00);
    pulse(14, e);
    pulse(15, e);
    repeat (3) @(posedge aclk);
    check(scsi_int_pending_flag, 1'b0);
    read_both(16'h0000);
    $display("done: gating");
    // Long bus reset counts once
    @(posedge aclk);
    scsi_rst_n <= 1'b0;
    repeat (8) @(posedge aclk);
    read_both(16'h0200);
    read_both(16'h0000);
    @(posedge aclk);
    scsi_rst_n <= 1'b1;
    repeat (8) @(posedge aclk);
    $display("done: bus reset");
    end_of_test;
  end
endmodule // test_sis_scsi_int_status
